// file: rtl/ctm_timer.sv
// compact 10-bit timer with compare, timer/counter and pwm modes
`timescale 1ns/100ps
// Contract
// - mode 00 selects compare match output
// - clear-select low: P match/overflow clears, both flags
// - clear-select high: A match clears, A flag only
// - clear-select high, A zero: overflow, no A flag
// - compare mode: only A match moves pin
// - pin function: none, low, high, toggle
// - counter-on rise loads initial pin level
// - mode 11 counts like compare mode
// - timer/counter mode leaves pin undriven
// - mode 10 is pwm; clear-select ignored
// - swap zero: P period, A duty
// - swap set: A period, P duty
// - duty at least period gives full active
// - pwm raises flag per comparator match
// - pwm polarity, pin function, inversion
// - pwm core runs under forced levels
// - compare A high byte: two bits, rest zero
// - counter-on rise clears, fall freezes count
// - P sets top three bits of the compare value, low seven bits zero
// - polarity inverts pin in every mode, timer mode included
module ctm_timer
	import ctm_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// timer tick from selected clock source
	input  wire logic        timer_tick,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// output pin
	output logic             timer_out,
	output logic             timer_out_en_n,
	// comparator event flags
	output logic             compare_a_flag,
	output logic             compare_p_flag,
	// selected clock source code
	output logic      [2:0]  clock_select
);

	logic [7:0]   ctrl0_r;
	logic [7:0]   ctrl1_r;
	logic [7:0]   cmpa_l_r;
	logic [1:0]   cmpa_h_r;
	logic [9:0]   count_r;
	logic         pin_r;
	logic         on_d_r;
	logic         flag_a_r;
	logic         flag_p_r;
	ctm_cfg_s     cfg;
	ctm_apb_req_s req;
	logic         acc;
	logic         wr;
	logic         on;
	logic         on_rise;
	logic [9:0]   cmpa;
	logic [2:0]   per;
	logic         match_a;
	logic         match_p;
	logic         clr_cnt;
	logic         ev_a;
	logic         ev_p;
	logic         pwm_mode;
	logic [10:0]  period_len;
	logic [10:0]  duty_len;
	logic         pwm_act;
	logic         pwm_lvl;
	logic         out_lvl;
	logic         addr_ok;

	// addressed register check
	function automatic logic ctm_mapped(input logic [7:0] a);
		ctm_mapped = (a == CTM_CTRL0_ADDR) || (a == CTM_CTRL1_ADDR) || (a == CTM_CNT_ADDR) ||
			(a == CTM_CMPA_L_ADDR) || (a == CTM_CMPA_H_ADDR) || (a == CTM_FLAG_ADDR);
	endfunction : ctm_mapped

	// 3-bit code to length in ticks, zero means 1024
	function automatic logic [10:0] ctm_p_len(input logic [2:0] p);
		ctm_p_len = (p == 3'h0) ? 11'h400 : {1'b0, p, 7'h00};
	endfunction : ctm_p_len

	assign req      = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign acc      = psel && penable;
	assign wr       = acc && req.write;
	assign addr_ok  = ctm_mapped(req.addr);
	assign pready   = 1'b1;
	assign pslverr  = acc && !addr_ok;
	assign cfg      = ctm_cfg_s'(ctrl1_r);
	assign on       = ctrl0_r[CTM_ON_BIT];
	assign on_rise  = on && !on_d_r;
	assign cmpa     = {cmpa_h_r, cmpa_l_r};
	assign per      = ctrl0_r[CTM_PER_LSB +: 3];
	assign pwm_mode = (cfg.mode == CTM_MODE_PWM);
	assign clock_select = ctrl0_r[CTM_CKSEL_LSB +: 3];

	// comparator matches, evaluated on the tick that reaches the value
	assign match_a = on && timer_tick && (count_r + 10'h001 == cmpa);
	assign match_p = on && timer_tick && (per != 3'h0) &&
		((count_r + 10'h001) == {per, 7'h00});

	// clear and flag selection
	always_comb begin
		clr_cnt = 1'b0;
		ev_a    = 1'b0;
		ev_p    = 1'b0;
		if (pwm_mode) begin
			ev_a    = match_a;
			ev_p    = match_p;
			clr_cnt = cfg.dpx ? match_a : match_p;
		end else if (cfg.clr_sel) begin
			ev_a    = match_a && (cmpa != 10'h000);
			clr_cnt = ev_a;
		end else begin
			ev_a    = match_a;
			ev_p    = match_p;
			clr_cnt = match_p;
		end
	end

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r  <= CTM_CTRL0_RST;
			ctrl1_r  <= CTM_CTRL1_RST;
			cmpa_l_r <= CTM_CMPA_L_RST;
			cmpa_h_r <= CTM_CMPA_H_RST;
		end else if (clk_en && wr) begin
			case (req.addr)
				CTM_CTRL0_ADDR:  ctrl0_r  <= req.wdata[7:0];
				CTM_CTRL1_ADDR:  ctrl1_r  <= req.wdata[7:0];
				CTM_CMPA_L_ADDR: cmpa_l_r <= req.wdata[7:0];
				CTM_CMPA_H_ADDR: cmpa_h_r <= req.wdata[1:0];
				default: ;
			endcase
		end
	end

	// counter-on edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_d_r <= 1'b0;
		end else if (clk_en) begin
			on_d_r <= on;
		end
	end

	// counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= 10'h000;
		end else if (clk_en) begin
			if (on_rise) begin
				count_r <= 10'h000;
			end else if (on && timer_tick) begin
				if (clr_cnt) begin
					count_r <= 10'h000;
				end else begin
					count_r <= count_r + 10'h001;
				end
			end
		end
	end

	// sticky flags, set wins over write-one-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
		end else if (clk_en) begin
			if (ev_a) begin
				flag_a_r <= 1'b1;
			end else if (wr && req.addr == CTM_FLAG_ADDR && req.wdata[CTM_FLAG_A_BIT]) begin
				flag_a_r <= 1'b0;
			end
			if (ev_p) begin
				flag_p_r <= 1'b1;
			end else if (wr && req.addr == CTM_FLAG_ADDR && req.wdata[CTM_FLAG_P_BIT]) begin
				flag_p_r <= 1'b0;
			end
		end
	end

	// compare mode pin state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= 1'b0;
		end else if (clk_en) begin
			if (on_rise) begin
				pin_r <= cfg.init_ctl;
			end else if (cfg.mode == CTM_MODE_CMP && ev_a) begin
				case (cfg.pin_func)
					CTM_PF_01: pin_r <= 1'b0;
					CTM_PF_10: pin_r <= 1'b1;
					CTM_PF_11: pin_r <= !pin_r;
					default:   pin_r <= pin_r;
				endcase
			end
		end
	end

	// pwm waveform, active while count is below duty
	always_comb begin
		period_len = cfg.dpx ? ((cmpa == 10'h000) ? 11'h400 : {1'b0, cmpa}) : ctm_p_len(per);
		duty_len   = cfg.dpx ? ctm_p_len(per) : {1'b0, cmpa};
		pwm_act    = (duty_len >= period_len) || ({1'b0, count_r} < duty_len);
		case (cfg.pin_func)
			CTM_PF_00: pwm_lvl = 1'b0;
			CTM_PF_01: pwm_lvl = 1'b1;
			CTM_PF_10: pwm_lvl = pwm_act;
			default:   pwm_lvl = 1'b0;
		endcase
		if (pwm_mode) begin
			out_lvl = cfg.init_ctl ? pwm_lvl : !pwm_lvl;
		end else begin
			out_lvl = pin_r;
		end
	end

	// output pin register and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out      <= 1'b0;
			timer_out_en_n <= 1'b1;
			prdata         <= 32'h0000_0000;
		end else if (clk_en) begin
			timer_out      <= out_lvl ^ cfg.polarity;
			timer_out_en_n <= (cfg.mode == CTM_MODE_TC);
			prdata         <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					CTM_CTRL0_ADDR:  prdata <= {24'h000000, ctrl0_r};
					CTM_CTRL1_ADDR:  prdata <= {24'h000000, ctrl1_r};
					CTM_CNT_ADDR:    prdata <= {22'h000000, count_r};
					CTM_CMPA_L_ADDR: prdata <= {24'h000000, cmpa_l_r};
					CTM_CMPA_H_ADDR: prdata <= {30'h00000000, cmpa_h_r};
					CTM_FLAG_ADDR:   prdata <= {30'h00000000, flag_p_r, flag_a_r};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign compare_a_flag = flag_a_r;
	assign compare_p_flag = flag_p_r;

endmodule : ctm_timer

// file: rtl/ctm_pkg.sv
// package for the compact timer: register map, fields, modes, types
package ctm_pkg;

	// register byte addresses
	localparam logic [7:0] CTM_CTRL0_ADDR  = 8'h00;
	localparam logic [7:0] CTM_CTRL1_ADDR  = 8'h04;
	localparam logic [7:0] CTM_CNT_ADDR    = 8'h08;
	localparam logic [7:0] CTM_CMPA_L_ADDR = 8'h0c;
	localparam logic [7:0] CTM_CMPA_H_ADDR = 8'h10;
	localparam logic [7:0] CTM_FLAG_ADDR   = 8'h14;

	// control zero fields
	localparam int CTM_ON_BIT     = 3;
	localparam int CTM_CKSEL_LSB  = 4;
	localparam int CTM_PER_LSB    = 0;
	// control one fields
	localparam int CTM_MODE_LSB   = 6;
	localparam int CTM_PINF_LSB   = 4;
	localparam int CTM_OINIT_BIT  = 3;
	localparam int CTM_POL_BIT    = 2;
	localparam int CTM_DPX_BIT    = 1;
	localparam int CTM_CCLR_BIT   = 0;
	// flag register fields
	localparam int CTM_FLAG_A_BIT = 0;
	localparam int CTM_FLAG_P_BIT = 1;

	// reset values and counter maximum
	localparam logic [7:0] CTM_CTRL0_RST  = 8'h00;
	localparam logic [7:0] CTM_CTRL1_RST  = 8'h00;
	localparam logic [7:0] CTM_CMPA_L_RST = 8'h00;
	localparam logic [1:0] CTM_CMPA_H_RST = 2'h0;
	localparam logic [9:0] CTM_CNT_MAX    = 10'h3ff;

	// operating modes
	localparam logic [1:0] CTM_MODE_CMP = 2'h0;
	localparam logic [1:0] CTM_MODE_PWM = 2'h2;
	localparam logic [1:0] CTM_MODE_TC  = 2'h3;

	// pin function codes
	localparam logic [1:0] CTM_PF_00 = 2'h0;
	localparam logic [1:0] CTM_PF_01 = 2'h1;
	localparam logic [1:0] CTM_PF_10 = 2'h2;
	localparam logic [1:0] CTM_PF_11 = 2'h3;

	// decoded configuration
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] pin_func;
		logic       init_ctl;
		logic       polarity;
		logic       dpx;
		logic       clr_sel;
	} ctm_cfg_s;

	// apb request
	typedef struct packed {
		logic [7:0]  addr;
		logic        write;
		logic [31:0] wdata;
	} ctm_apb_req_s;

endpackage : ctm_pkg

// file: dv/ctm_props.sv
// port assertions for the compact timer
`timescale 1ns/100ps
module ctm_props
	import ctm_pkg::*;
(
	// clock, reset, tick
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        timer_tick,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pin and flags
	input wire logic        timer_out,
	input wire logic        timer_out_en_n,
	input wire logic        compare_a_flag,
	input wire logic        compare_p_flag,
	input wire logic [2:0]  clock_select
);
	logic [7:0] c1_r;
	logic       acc;
	assign acc = psel && penable && clk_en;
	// shadow of control one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			c1_r <= 8'h00;
		else if (acc && pwrite && paddr == CTM_CTRL1_ADDR)
			c1_r <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (pready) else $error("pready low");
	err_in_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	high_byte_zero_a: assert property (acc && !pwrite && paddr == CTM_CMPA_H_ADDR |-> prdata[31:2] == 30'h0)
		else $error("upper bits set");
	a_flag_tick_a: assert property ($rose(compare_a_flag) |-> $past(timer_tick))
		else $error("a flag without tick");
	p_flag_tick_a: assert property ($rose(compare_p_flag) |-> $past(timer_tick))
		else $error("p flag without tick");
	p_flag_blocked_a: assert property ($stable(c1_r) && c1_r[0] && c1_r[7:6] != CTM_MODE_PWM
		|-> !$rose(compare_p_flag)) else $error("p flag with a clear");
	flag_clear_a: assert property (acc && pwrite && paddr == CTM_FLAG_ADDR && pwdata[0] && !timer_tick
		|=> !compare_a_flag) else $error("a flag not cleared");
	tc_undriven_a: assert property ($stable(c1_r) && c1_r[7:6] == CTM_MODE_TC |-> timer_out_en_n)
		else $error("pin driven in timer mode");
	cover property ($rose(compare_a_flag));
	cover property ($rose(compare_p_flag));
	cover property (pslverr);
endmodule : ctm_props
bind ctm_timer ctm_props ctm_props_i (.pclk, .presetn, .clk_en, .timer_tick, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_out, .timer_out_en_n, .compare_a_flag,
	.compare_p_flag, .clock_select);

// file: dv/test_compact_timer_modes.sv
// register level testbench for the compact timer
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module test_compact_timer_modes;
	import ctm_pkg::*;
	logic        pclk, presetn, clk_en, timer_tick, psel, penable, pwrite, pready, pslverr, er;
	logic        timer_out, timer_out_en_n, compare_a_flag, compare_p_flag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [2:0]  clock_select;
	logic [7:0]  pin_tab = 8'h5c;
	logic [7:0]  frc_c1 [4] = '{8'h88, 8'h98, 8'h8c, 8'h9c};
	logic        frc_e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	int          failures, compares;
	ctm_timer ctm_timer_i (.pclk, .presetn, .clk_en, .timer_tick, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .timer_out, .timer_out_en_n, .compare_a_flag,
		.compare_p_flag, .clock_select);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic ch(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK(rv, e)
	endtask : ch
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			timer_tick <= 1'b1;
		end
		@(posedge pclk);
		timer_tick <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : ticks
	// stop, set mode, start
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
		wr(CTM_CTRL0_ADDR, 32'h0);
		wr(CTM_CTRL1_ADDR, {24'h0, c1});
		wr(CTM_CTRL0_ADDR, {24'h0, c0});
		repeat (3) @(posedge pclk);
	endtask : cfg
	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		#500000;
		failures++;
		close_out;
	end
	initial begin
		{presetn, timer_tick, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			ch(8'(i * 4), 32'h0);
			`CHK(er, i == 6)
		end
		wr(CTM_CMPA_H_ADDR, 32'hff);
		ch(CTM_CMPA_H_ADDR, 32'h3);
		wr(CTM_CMPA_H_ADDR, 32'h0);
		wr(CTM_CMPA_L_ADDR, 32'h3);
		wr(CTM_CTRL0_ADDR, 32'h70);
		ch(CTM_CTRL0_ADDR, 32'h70);
		`CHK(clock_select, 3'h7)
		wr(CTM_CTRL0_ADDR, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			cfg({CTM_MODE_CMP, i[1:0], i[2], 3'h1}, 8'h08);
			`CHK(timer_out, i[2])
			`CHK(timer_out_en_n, 1'b0)
			ticks(2);
			`CHK(timer_out, i[2])
			ticks(1);
			`CHK(timer_out, pin_tab[i])
		end
		ch(CTM_CNT_ADDR, 32'h0);
		ch(CTM_FLAG_ADDR, 32'h1);
		`CHK({compare_p_flag, compare_a_flag}, 2'h1)
		ticks(2);
		wr(CTM_CTRL0_ADDR, 32'h0);
		ticks(2);
		ch(CTM_CNT_ADDR, 32'h2);
		wr(CTM_FLAG_ADDR, 32'h3);
		ch(CTM_FLAG_ADDR, 32'h0);
		cfg(8'h00, 8'h09);
		ticks(128);
		ch(CTM_CNT_ADDR, 32'h0);
		ch(CTM_FLAG_ADDR, 32'h3);
		wr(CTM_FLAG_ADDR, 32'h3);
		wr(CTM_CMPA_L_ADDR, 32'h0);
		cfg(8'h01, 8'h08);
		ticks(1023);
		ch(CTM_CNT_ADDR, 32'h3ff);
		ticks(1);
		ch(CTM_CNT_ADDR, 32'h0);
		ch(CTM_FLAG_ADDR, 32'h0);
		$display("test compare done");
		wr(CTM_CMPA_L_ADDR, 32'h3);
		cfg(8'hc1, 8'h08);
		`CHK(timer_out_en_n, 1'b1)
		ticks(3);
		ch(CTM_FLAG_ADDR, 32'h1);
		wr(CTM_FLAG_ADDR, 32'h3);
		$display("test timer done");
		wr(CTM_CMPA_L_ADDR, 32'd32);
		cfg(8'ha9, 8'h09);
		ticks(10);
		`CHK(timer_out, 1'b1)
		ticks(40);
		`CHK(timer_out, 1'b0)
		ticks(78);
		`CHK(timer_out, 1'b1)
		ch(CTM_CNT_ADDR, 32'h0);
		ch(CTM_FLAG_ADDR, 32'h3);
		wr(CTM_CMPA_L_ADDR, 32'd200);
		cfg(8'hab, 8'h09);
		ticks(150);
		`CHK(timer_out, 1'b0)
		ticks(50);
		ch(CTM_CNT_ADDR, 32'h0);
		cfg(8'ha8, 8'h09);
		ticks(127);
		`CHK(timer_out, 1'b1)
		for (int i = 0; i < 4; i++) begin
			cfg(frc_c1[i], 8'h09);
			`CHK(timer_out, frc_e[i])
			ticks(5);
			ch(CTM_CNT_ADDR, 32'h5);
		end
		clk_en <= 1'b0;
		ticks(4);
		clk_en <= 1'b1;
		ch(CTM_CNT_ADDR, 32'h5);
		$display("test pwm done");
		close_out;
	end
endmodule : test_compact_timer_modes
